// >>> design/watch_counter.sv
`timescale 1ns/1ps
`default_nettype none
module watch_counter
  import watch_timer_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic advance,
  input  wire logic clear,
  output logic      wrap16,
  output logic      wrap32
);

  counter_state_t st;
  counter_state_t nx;

  // Five-bit counter, cleared while stopped
  always_comb begin
    nx = st;
    if (clear) begin
      nx.cnt = 5'h00;
    end else if (advance) begin
      nx.cnt = st.cnt + 5'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  // Wrap of low four bits and of all five
  assign wrap16 = advance & ~clear & (&st.cnt[3:0]);
  assign wrap32 = advance & ~clear & (&st.cnt);

endmodule
`default_nettype wire

// >>> design/watch_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module watch_prescaler
  import watch_timer_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        tick,
  input  wire logic        clear,
  output logic      [10:0] tap
);

  presc_state_t st;
  presc_state_t nx;

  // Count watch clock ticks, clear while stopped
  always_comb begin
    nx = st;
    if (clear) begin
      nx.cnt = 11'h000;
    end else if (tick) begin
      nx.cnt = st.cnt + 11'h001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  // Tap k pulses once per 2^(k+1) ticks
  for (genvar k = 0; k < 11; k++) begin : g_tap
    assign tap[k] = tick & ~clear & (&st.cnt[k:0]);
  end

endmodule
`default_nettype wire

// >>> design/watch_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "watch_timer_map.svh"
module watch_timer
  import watch_timer_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [17:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [17:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        sub_clk_in,
  output logic             watch_irq,
  output logic             interval_irq,
  output logic             irq
);

  top_state_t st;
  top_state_t nx;

  logic        en;
  logic        run_on;
  logic        fw_tick;
  logic [10:0] tap;
  logic        wrap16;
  logic        wrap32;
  logic        short_evt;
  logic        long_evt;
  logic        watch_evt;
  logic        interval_evt;
  logic [3:0]  ival_idx;

  // Operating state from the mode register
  assign en     = st.mode.timer_enable_bit;
  assign run_on = en & st.mode.counter_run_bit;

  // Watch clock: divided main clock or subclock rising edge
  assign fw_tick = en & (st.mode.clock_source_sel ? (sub_clk_in & ~st.sub_prev)
                                                  : (st.div == `WT_DIV_LAST));

  // Shared prescaler, cleared only by the enable bit
  watch_prescaler u_prescaler (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (fw_tick),
    .clear   (~en),
    .tap     (tap)
  );

  // Counter steps once per 2^9 watch clocks
  watch_counter u_counter (
    .aclk    (aclk),
    .aresetn (aresetn),
    .advance (run_on & tap[`WT_LONG_TAP]),
    .clear   (~run_on),
    .wrap16  (wrap16),
    .wrap32  (wrap32)
  );

  // Watch event selection
  assign short_evt = st.mode.irq_time_sel[0] ? tap[`WT_SHORT_TAP_LO] : tap[4];
  assign long_evt  = st.mode.irq_time_sel[0] ? wrap16 : wrap32;
  assign watch_evt = run_on & (st.mode.irq_time_sel[1] ? short_evt : long_evt);

  // Interval event from prescaler tap, independent of the counter
  assign ival_idx     = 4'(`WT_SHORT_TAP_LO) + {1'b0, st.mode.interval_sel};
  assign interval_evt = en & tap[ival_idx];

  // Next state: divider, events, bus slave
  always_comb begin
    logic [1:0]  clr;
    logic [1:0]  set;
    logic [7:0]  mode_bits;
    logic [15:0] w_idx;
    logic [15:0] r_idx;
    clr       = 2'h0;
    set       = 2'h0;
    mode_bits = st.mode;
    w_idx     = st.aw_addr[17:2];
    r_idx     = s_axi_araddr[17:2];
    nx        = st;

    // Divide by 128 while enabled
    nx.div      = en ? st.div + 7'h01 : 7'h00;
    nx.sub_prev = sub_clk_in;

    // Event pulses out
    nx.watch_pulse    = watch_evt;
    nx.interval_pulse = interval_evt;
    set[`WT_EVT_WATCH]    = watch_evt;
    set[`WT_EVT_INTERVAL] = interval_evt;

    // Write address and data captured independently
    if (s_axi_awvalid && st.aw_open) begin
      nx.aw_open = 1'b0;
      nx.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.w_open) begin
      nx.w_open = 1'b0;
      nx.w_data = s_axi_wdata;
      nx.w_strb = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready) begin
      nx.bvalid = 1'b0;
    end

    // Perform write once both halves are held
    if (!st.aw_open && !st.w_open && !st.bvalid) begin
      nx.aw_open = 1'b1;
      nx.w_open  = 1'b1;
      nx.bvalid  = 1'b1;
      nx.bresp   = `WT_RESP_OKAY;
      unique case (w_idx)
        `WT_MODE_IDX: begin
          if (st.w_strb[0]) begin
            nx.mode = mode_t'(st.w_data[7:0]);
          end
        end
        `WT_STATUS_IDX: begin
          if (st.w_strb[0]) begin
            clr = st.w_data[1:0];
          end
        end
        `WT_MASK_IDX: begin
          if (st.w_strb[0]) begin
            nx.mask = st.w_data[1:0];
          end
        end
        `WT_BITOP_IDX: begin
          if (st.w_strb[0]) begin
            mode_bits[st.w_data[2:0]] = st.w_data[`WT_BITOP_VAL_POS];
            nx.mode = mode_t'(mode_bits);
          end
        end
        default: begin
          nx.bresp = `WT_RESP_SLVERR;
        end
      endcase
    end

    // Sticky status, a new event wins over the clear
    nx.status = (st.status & ~clr) | set;
    nx.irq    = |(nx.status & nx.mask);

    // Read channel
    if (st.rvalid && s_axi_rready) begin
      nx.rvalid  = 1'b0;
      nx.ar_open = 1'b1;
    end
    if (s_axi_arvalid && st.ar_open) begin
      nx.ar_open = 1'b0;
      nx.rvalid  = 1'b1;
      nx.rresp   = `WT_RESP_OKAY;
      unique case (r_idx)
        `WT_MODE_IDX: begin
          nx.rdata = {24'h00_0000, st.mode};
        end
        `WT_STATUS_IDX: begin
          nx.rdata = {30'h0000_0000, st.status};
        end
        `WT_MASK_IDX: begin
          nx.rdata = {30'h0000_0000, st.mask};
        end
        `WT_BITOP_IDX: begin
          nx.rdata = 32'h0000_0000;
        end
        default: begin
          nx.rdata = 32'h0000_0000;
          nx.rresp = `WT_RESP_SLVERR;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st         <= '0;
      st.mode    <= mode_t'(`WT_MODE_RESET);
      st.status  <= `WT_IRQ_RESET;
      st.mask    <= `WT_IRQ_RESET;
      st.aw_open <= 1'b1;
      st.w_open  <= 1'b1;
      st.ar_open <= 1'b1;
    end else begin
      st <= nx;
    end
  end

  // Outputs straight from the state register
  assign s_axi_awready = st.aw_open;
  assign s_axi_wready  = st.w_open;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = st.ar_open;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;
  assign watch_irq     = st.watch_pulse;
  assign interval_irq  = st.interval_pulse;
  assign irq           = st.irq;

endmodule
`default_nettype wire

// >>> design/watch_timer_map.svh
// Functional notes
// - Watch clock is the main clock divided by 128, or subclock edges when selected.
// - Interval interrupt every 2^4 to 2^11 watch clocks, per the three-bit field.
// - Watch interrupt every 2^14, 2^13, 2^5 or 2^4 watch clocks, per two-bit field.
// - Counter-run bit high starts the 5-bit counter; low stops and clears it.
// - Enable bit low stops everything and clears prescaler and 5-bit counter.
// - Reset clears the whole mode register to zero.
// - Mode register takes whole-byte writes and single-bit writes touching one bit.
// - Watch and interval interrupts run together from the shared prescaler.
// - Clearing only counter-run resets the counter, not the prescaler.
`ifndef WATCH_TIMER_MAP_SVH
`define WATCH_TIMER_MAP_SVH

// Register indices; byte address is four times the index
`define WT_MODE_IDX      16'hFF8F
`define WT_STATUS_IDX    16'hFF90
`define WT_MASK_IDX      16'hFF91
`define WT_BITOP_IDX     16'hFF92
`define WT_ADDR_W        18

// Reset values
`define WT_MODE_RESET    8'h00
`define WT_IRQ_RESET     2'h0

// Status and mask bit positions
`define WT_EVT_WATCH     0
`define WT_EVT_INTERVAL  1

// Single-bit write register fields
`define WT_BITOP_VAL_POS 3

// Timing
`define WT_PERIPH_DIV    128
`define WT_DIV_LAST      7'h7F
`define WT_LONG_TAP      8
`define WT_SHORT_TAP_LO  3

// Bus answers
`define WT_RESP_OKAY     2'h0
`define WT_RESP_SLVERR   2'h2

`endif

// >>> design/watch_timer_pkg.sv
package watch_timer_pkg;

  // Mode register layout, bit 7 down to bit 0
  typedef struct packed {
    logic       clock_source_sel;
    logic [2:0] interval_sel;
    logic [1:0] irq_time_sel;
    logic       counter_run_bit;
    logic       timer_enable_bit;
  } mode_t;

  typedef struct packed {
    logic [10:0] cnt;
  } presc_state_t;

  typedef struct packed {
    logic [4:0] cnt;
  } counter_state_t;

  typedef struct packed {
    mode_t       mode;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic [6:0]  div;
    logic        sub_prev;
    logic        aw_open;
    logic [17:0] aw_addr;
    logic        w_open;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        ar_open;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        watch_pulse;
    logic        interval_pulse;
    logic        irq;
  } top_state_t;

endpackage

// >>> dv/watch_timer_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module watch_timer_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        watch_irq,
  input wire logic        interval_irq,
  input wire logic        irq
);
  // Bus clock domain, quiet during reset
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  aw_take_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("awready high after take");
  b_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer not held");
  r_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  r_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  watch_pulse_a: assert property (watch_irq |=> !watch_irq)
    else $error("watch pulse too long");
  interval_pulse_a: assert property (interval_irq |=> !interval_irq)
    else $error("interval pulse too long");
  irq_rise_a: assert property (
    $rose(irq) |-> watch_irq || interval_irq || $rose(s_axi_bvalid))
    else $error("irq rose without cause");
  irq_fall_a: assert property ($fell(irq) |-> $rose(s_axi_bvalid))
    else $error("irq fell without write");
  reset_quiet_a: assert property (@(posedge aclk) disable iff (1'b0)
    !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !irq && !watch_irq)
    else $error("outputs active after reset");
  // Main scenarios reached
  watch_seen_c: cover property (watch_irq);
  interval_seen_c: cover property (interval_irq);
  irq_seen_c: cover property (irq && watch_irq);
endmodule
bind watch_timer watch_timer_monitor watch_timer_monitor_i (.*);
`default_nettype wire

// >>> dv/watch_timer_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "watch_timer_map.svh"
module watch_timer_test;
  logic        aclk = 0, aresetn = 0, sub_clk_in = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic [17:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, d, seed = 32'h4d76;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  r;
  logic        bv;
  logic [7:0]  mode_m;
  wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic   watch_irq, interval_irq, irq;
  wire logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  int          mismatches = 0, n_tests = 0, cyc = 0, nw, ni;

  watch_timer watch_timer_i (.*);

  // Bus clock, and a fast watch clock source
  initial begin
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk) sub_clk_in <= ~sub_clk_in;

  // Hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 100000) begin
      mismatches++;
      report_and_stop();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // One write; ready and answer sampled mid-cycle, released after the edge
  task automatic wr(input logic [15:0] i, input logic [7:0] v);
    logic ta, tw, tb;
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
    end while (!tb);
    s_axi_bready <= 0;
    @(posedge aclk);
    chk(r, `WT_RESP_OKAY);
  endtask

  // One read, compared with the model value and answer code
  task automatic rdc(input logic [15:0] i, input logic [31:0] exp, input logic [1:0] er);
    logic ta, tb;
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tb = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 0;
    end while (!tb);
    s_axi_rready <= 0;
    @(posedge aclk);
    chk(d, exp);
    chk(r, er);
  endtask

  // Cycles between two pulses of one output
  task automatic measure(input bit w, input int exp);
    int n;
    do @(negedge aclk); while ((w ? watch_irq : interval_irq) !== 1'b1);
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while ((w ? watch_irq : interval_irq) !== 1'b1);
    chk(n, exp);
    @(posedge aclk);
  endtask

  task automatic chk_irq(input logic e);
    @(negedge aclk);
    chk({31'h0, irq}, {31'h0, e});
    @(posedge aclk);
  endtask

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rdc(`WT_MODE_IDX, 0, `WT_RESP_OKAY);
    rdc(`WT_STATUS_IDX, 0, `WT_RESP_OKAY);
    rdc(16'h0000, 0, `WT_RESP_SLVERR);
    wr(`WT_MASK_IDX, 8'h03);
    wr(`WT_MODE_IDX, 8'h01);
    measure(0, 16 * `WT_PERIPH_DIV);
    wr(`WT_MODE_IDX, 8'h00);
    // Every interval code, watch running beside it; source two cycles a tick
    for (int s = 0; s < 8; s++) begin
      wr(`WT_MODE_IDX, {1'b1, s[2:0], 4'b1111});
      measure(0, 2 << (4 + s));
      wr(`WT_MODE_IDX, 8'h00);
    end
    for (int k = 3; k > 0; k--) begin
      wr(`WT_MODE_IDX, {1'b1, 3'b000, k[1:0], 2'b11});
      measure(1, k == 1 ? 2 << 13 : 2 << (7 - k));
    end
    rdc(`WT_STATUS_IDX, 3, `WT_RESP_OKAY);
    chk_irq(1);
    // Counter stopped while prescaler keeps running
    wr(`WT_BITOP_IDX, 8'h01);
    nw = 0;
    ni = 0;
    repeat (100) begin
      @(negedge aclk);
      nw += (watch_irq !== 1'b0);
      ni += (interval_irq === 1'b1);
    end
    @(posedge aclk);
    chk(nw, 0);
    chk(ni >= 3, 1);
    // Slowest watch period: restarted counter stays quiet past 2^13 ticks
    wr(`WT_MODE_IDX, 8'h83);
    nw = 0;
    repeat (16500) begin
      @(negedge aclk);
      nw += (watch_irq !== 1'b0);
    end
    @(posedge aclk);
    chk(nw, 0);
    wr(`WT_MASK_IDX, 8'h00);
    chk_irq(0);
    wr(`WT_MASK_IDX, 8'h03);
    wr(`WT_MODE_IDX, 8'h00);
    wr(`WT_STATUS_IDX, 8'h03);
    repeat (300) @(posedge aclk);
    rdc(`WT_STATUS_IDX, 0, `WT_RESP_OKAY);
    chk_irq(0);
    // Random single-bit writes against a byte model
    mode_m = 0;
    repeat (8) begin
      seed = xs(seed);
      // Enable kept low, so source and interval change only while stopped
      bv = seed[3] & (seed[2:0] != 3'h0);
      wr(`WT_BITOP_IDX, {4'h0, bv, seed[2:0]});
      mode_m[seed[2:0]] = bv;
      rdc(`WT_MODE_IDX, mode_m, `WT_RESP_OKAY);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
